/* File: logic/wdc_watchdog.sv */
// Watchdog down counter ticking on the low-speed clock, with interrupt and reset
`timescale 1ns/1ps

module wdc_watchdog #(
  parameter int unsigned RST_PULSE_CYC = wdc_pkg::WDC_RST_PULSE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Low-speed 32.768 kHz clock, asynchronous to i_clk
  input wire logic i_lsclk,
  // Standby indication from the power controller
  input wire logic i_standby,
  // Software controls
  input wire wdc_pkg::wdc_ctrl_t i_ctrl,
  // Status and events
  output wdc_pkg::wdc_stat_t o_stat
);
  import wdc_pkg::*;

  // Pulse counter width; RST_PULSE_CYC must fit in it
  localparam int unsigned RST_CNT_W = 8;
  localparam logic [RST_CNT_W-1:0] RST_CNT_LOAD = RST_PULSE_CYC[RST_CNT_W-1:0];

  // A zero-length pulse would never reach the system
  if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin : g_bad_pulse
    $error("RST_PULSE_CYC must be 1..255");
  end

  // Reset values and the decrement are written at this width
  if (WDC_CNT_W != 32) begin : g_bad_width
    $error("WDC_CNT_W must be 32");
  end

  // Low-speed clock synchroniser and edge detector
  logic ls_meta;
  logic ls_sync;
  logic ls_prev;
  logic tick;

  // Counter path
  logic [WDC_CNT_W-1:0] reload_value;
  logic [WDC_CNT_W-1:0] next_reload_value;
  logic [WDC_CNT_W-1:0] count;
  logic [WDC_CNT_W-1:0] next_count;
  logic count_zero;
  logic dec_en;
  logic timeout;

  // Flag, wake request and reset pulse
  logic flag;
  logic next_flag;
  logic wake;
  logic next_wake;
  logic serviced;
  logic reset_trig;
  logic [RST_CNT_W-1:0] rst_cnt;
  logic [RST_CNT_W-1:0] next_rst_cnt;
  logic sys_reset;
  logic next_sys_reset;

  // Reset high so a high low-speed clock at release is no edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ls_meta <= 1'b1;
      ls_sync <= 1'b1;
    end else begin
      ls_meta <= i_lsclk;
      ls_sync <= ls_meta;
    end
  end

  // Edge detector reads only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ls_prev <= 1'b1;
    end else begin
      ls_prev <= ls_sync;
    end
  end

  // One tick per rising edge of the low-speed clock
  assign tick = ls_sync & ~ls_prev;

  // Software load replaces the stored reload value
  always_comb begin
    next_reload_value = reload_value;
    if (i_ctrl.load_strobe) begin
      next_reload_value = i_ctrl.reload_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reload_value <= WDC_RST_RELOAD;
    end else begin
      reload_value <= next_reload_value;
    end
  end

  // Counter is at its last tick
  assign count_zero = (count == '0);
  // Standby does not gate the counter: only enable does
  assign dec_en = i_ctrl.enable & tick;
  assign timeout = dec_en & count_zero;

  // Load beats restart, restart beats timeout, timeout beats decrement
  always_comb begin
    next_count = count;
    if (i_ctrl.load_strobe) begin
      next_count = i_ctrl.reload_value;
    end else if (i_ctrl.restart) begin
      next_count = reload_value;
    end else if (timeout) begin
      next_count = reload_value;
    end else if (dec_en) begin
      next_count = count - 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= WDC_RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Set beats clear so a timeout in the clearing cycle is kept
  always_comb begin
    next_flag = flag;
    if (timeout) begin
      next_flag = 1'b1;
    end else if (i_ctrl.clear_flag) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // Wake request held until the system leaves standby
  always_comb begin
    next_wake = wake;
    if (timeout && i_standby) begin
      next_wake = 1'b1;
    end else if (!i_standby) begin
      next_wake = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake <= 1'b0;
    end else begin
      wake <= next_wake;
    end
  end

  // A clear in the timeout cycle still counts as serviced
  assign serviced = ~flag | i_ctrl.clear_flag;
  assign reset_trig = timeout & ~serviced;

  // Counts down the remaining cycles of the reset pulse
  always_comb begin
    next_rst_cnt = rst_cnt;
    if (reset_trig) begin
      next_rst_cnt = RST_CNT_LOAD;
    end else if (rst_cnt != 8'h00) begin
      next_rst_cnt = rst_cnt - 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rst_cnt <= 8'h00;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  // High from the trigger until the counter runs out
  always_comb begin
    next_sys_reset = sys_reset;
    if (reset_trig) begin
      next_sys_reset = 1'b1;
    end else if (rst_cnt <= 8'h01) begin
      next_sys_reset = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sys_reset <= 1'b0;
    end else begin
      sys_reset <= next_sys_reset;
    end
  end

  // Status taps; every field is a register
  always_comb begin
    o_stat.irq = flag;
    o_stat.flag = flag;
    o_stat.wakeup = wake;
    o_stat.sys_reset = sys_reset;
    o_stat.count = count;
  end
endmodule : wdc_watchdog

/* File: shared/wdc_pkg.sv */
// Package of constants and carrier types for the watchdog down counter
package wdc_pkg;
  localparam int unsigned WDC_CNT_W = 32;
  localparam int unsigned WDC_SYS_CLK_HZ = 100_000_000;
  localparam logic [31:0] WDC_RST_RELOAD = 32'hffff_ffff;
  localparam logic [31:0] WDC_RST_COUNT = 32'hffff_ffff;
  localparam int unsigned WDC_RST_PULSE_CYC = 16;

  // Software side controls, sampled every system clock
  typedef struct packed {
    logic enable;
    logic load_strobe;
    logic [WDC_CNT_W-1:0] reload_value;
    logic clear_flag;
    logic restart;
  } wdc_ctrl_t;

  // Status seen by software and the power controller
  typedef struct packed {
    logic irq;
    logic flag;
    logic wakeup;
    logic sys_reset;
    logic [WDC_CNT_W-1:0] count;
  } wdc_stat_t;
endpackage : wdc_pkg

/* File: tb/tb_wdc_watchdog.sv */
// Testbench of the watchdog down counter
`timescale 1ns/1ps
module tb_wdc_watchdog;
  import wdc_pkg::*;
  logic i_clk = 0, i_rst = 1, i_lsclk = 0, i_standby = 0;
  wdc_ctrl_t i_ctrl = '0;
  wdc_stat_t o_stat;
  int n_fail = 0, n_compared = 0, cyc = 0;
  wdc_watchdog u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_lsclk(i_lsclk),
    .i_standby(i_standby), .i_ctrl(i_ctrl), .o_stat(o_stat));
  initial forever #5 i_clk = ~i_clk;
  // Low-speed clock moves just after a system edge, as every other input
  always begin
    repeat (1526) @(posedge i_clk);
    #1 i_lsclk = ~i_lsclk;
  end
  always @(posedge i_clk) if (++cyc > 60000) begin n_fail++; print_verdict(); end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin n_fail++; $display("wrong value %0t %h %h", $time, got, exp); end
  endtask : cmp
  // Timeout seen as count leaving zero by reload
  task automatic tmo;
    wait (o_stat.count == 32'h0);
    wait (o_stat.count != 32'h0);
    #1;
  endtask : tmo
  task automatic pulse(input wdc_ctrl_t c);
    @(posedge i_clk);
    #1 i_ctrl = c;
    @(posedge i_clk);
    #1 i_ctrl = '{1'b1, 1'b0, 32'h1, 1'b0, 1'b0};
  endtask : pulse
  task automatic t_timeout;
    pulse('{1'b1, 1'b1, 32'h1, 1'b0, 1'b0});
    tmo();
    cmp(o_stat.count, 32'h1);
    cmp(o_stat.irq, 1'b1);
    cmp(o_stat.sys_reset, 1'b0);
    tmo();
    cmp(o_stat.sys_reset, 1'b1);
    cmp(o_stat.flag, 1'b1);
  endtask : t_timeout
  task automatic t_clear;
    pulse('{1'b1, 1'b0, 32'h1, 1'b1, 1'b0});
    cmp(o_stat.irq, 1'b0);
    tmo();
    cmp(o_stat.sys_reset, 1'b0);
  endtask : t_clear
  task automatic t_wake;
    pulse('{1'b1, 1'b0, 32'h1, 1'b1, 1'b0});
    i_standby = 1;
    tmo();
    cmp(o_stat.wakeup, 1'b1);
    cmp(o_stat.count, 32'h1);
    i_standby = 0;
  endtask : t_wake
  task automatic t_off;
    @(posedge i_clk);
    #1 i_ctrl = '{1'b0, 1'b1, 32'h5, 1'b0, 1'b0};
    @(posedge i_clk);
    #1 i_ctrl.load_strobe = 1'b0;
    repeat (2) @(posedge i_lsclk);
    repeat (4) @(posedge i_clk);
    #1 cmp(o_stat.count, 32'h5);
    i_ctrl.enable = 1'b1;
    @(posedge i_lsclk);
    repeat (4) @(posedge i_clk);
    #1 cmp(o_stat.count, 32'h4);
    @(posedge i_clk);
    #1 i_ctrl.restart = 1'b1;
    @(posedge i_clk);
    #1 i_ctrl.restart = 1'b0;
    cmp(o_stat.count, 32'h5);
  endtask : t_off
  // Clear lands in the very cycle of a timeout while the flag is pending
  task automatic t_race;
    @(posedge i_clk);
    #1 i_ctrl = '{1'b1, 1'b1, 32'h0, 1'b0, 1'b0};
    @(posedge i_clk);
    #1 i_ctrl.load_strobe = 1'b0;
    @(posedge i_lsclk);
    repeat (2) @(posedge i_clk);
    #1 i_ctrl.clear_flag = 1'b1;
    @(posedge i_clk);
    #1 i_ctrl.clear_flag = 1'b0;
    cmp(o_stat.flag, 1'b1);
    cmp(o_stat.sys_reset, 1'b0);
    cmp(o_stat.count, 32'h0);
  endtask : t_race
  task automatic print_verdict;
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_rst = 0;
    t_timeout();
    t_clear();
    t_wake();
    t_off();
    t_race();
    print_verdict();
  end
endmodule : tb_wdc_watchdog

/* File: tb/wdc_watchdog_sva.sv */
// Port checker of the watchdog down counter
`timescale 1ns/1ps
module wdc_watchdog_sva (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_standby,
  input wire wdc_pkg::wdc_ctrl_t i_ctrl,
  input wire wdc_pkg::wdc_stat_t o_stat
);
  import wdc_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_irq; o_stat.irq == o_stat.flag; endproperty
  a_irq: assert property (p_irq) else $error("irq differs from flag");
  property p_set; $rose(o_stat.flag) |-> $past(o_stat.count) == 32'h0; endproperty
  a_set: assert property (p_set) else $error("flag set without zero");
  property p_hold; o_stat.flag && !i_ctrl.clear_flag |=> o_stat.flag; endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_rst;
    $rose(o_stat.sys_reset) |-> $past(o_stat.flag) && $past(o_stat.count) == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset without pending flag");
  property p_idle;
    !i_ctrl.enable && !i_ctrl.load_strobe && !i_ctrl.restart |=> $stable(o_stat.count);
  endproperty
  a_idle: assert property (p_idle) else $error("count moved while off");
  property p_wake; $rose(o_stat.wakeup) |-> $past(i_standby); endproperty
  a_wake: assert property (p_wake) else $error("wakeup outside standby");
  // Default pulse of sixteen cycles, split so each repetition stays short
  sequence s_rst_half;
    o_stat.sys_reset [*8];
  endsequence
  sequence s_rst_done;
    !o_stat.sys_reset;
  endsequence
  property p_rst_len;
    $rose(o_stat.sys_reset) |-> s_rst_half ##1 s_rst_half ##1 s_rst_done;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_clr; i_ctrl.clear_flag && o_stat.count != 32'h0 |=> !o_stat.flag; endproperty
  a_clr: assert property (p_clr) else $error("flag kept after clear");
  property p_spare; i_ctrl.clear_flag |=> !$rose(o_stat.sys_reset); endproperty
  a_spare: assert property (p_spare) else $error("reset despite clear");
endmodule : wdc_watchdog_sva
bind wdc_watchdog wdc_watchdog_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_standby(i_standby), .i_ctrl(i_ctrl), .o_stat(o_stat));
